//--- hdl/fsf_pkg.sv
// package of constants and carriers for the flash status poll controller
//Contract
//- host ends and restarts the read strobe for every toggle status sample.
//- extra 30H block erase accepted in window; host may check flag after each.
//- ready/busy is open drain, wire-ORed, pull-up on the board.
//- host must poll at an address inside the bank running the routine.
`default_nettype none
package fsf_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 20;
   localparam int T_RD_NS = 100;
   localparam int RD_CYC = (T_RD_NS * CLK_MHZ + 999) / 1000;
   localparam int T_GAP_NS = 50;
   localparam int GAP_CYC = (T_GAP_NS * CLK_MHZ + 999) / 1000;
   localparam int T_ERWIN_US = 50;
   localparam int ERWIN_CYC = T_ERWIN_US * CLK_MHZ;
   // ----------------------------------------
   // flag bit positions on the data bus
   // ----------------------------------------
   localparam int B_POLL = 7;
   localparam int B_TOG1 = 6;
   localparam int B_TMO = 5;
   localparam int B_ERWIN = 3;
   localparam int B_TOG2 = 2;
   // ----------------------------------------
   // software port offsets
   // ----------------------------------------
   localparam logic [3:0] A_CTRL = 4'h0;
   localparam logic [3:0] A_ADDR = 4'h1;
   localparam logic [3:0] A_EXP = 4'h2;
   localparam logic [3:0] A_STAT = 4'h3;
   localparam logic [3:0] A_DATA = 4'h4;
   localparam logic [15:0] DQ_RST = 16'h0000;
   typedef enum logic [1:0] {FSF_POLL_DATA, FSF_POLL_TOGGLE} fsf_mode_e;
   // result of one poll cycle
   typedef struct packed {
      logic done;
      logic fail;
      logic erwin_closed;
      logic ready;
   } fsf_res_s;
   typedef enum {ST_IDLE, ST_RD, ST_GAP, ST_EVAL} fsf_st_e;
endpackage
`default_nettype wire

//--- hdl/fsf_sync.sv
// two flop synchroniser for flash pins
`default_nettype none
module fsf_sync #(parameter int W = 1) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta;
   // ----------------------------------------
   // double flop, first stage read by second only
   // ----------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         meta <= '0;
         o_q <= '0;
      end else begin
         meta <= i_d;
         o_q <= meta;
      end
   end
endmodule
`default_nettype wire

//--- hdl/fsf_poll_ctrl.sv
// host controller polling the flash status flags
`default_nettype none
module fsf_poll_ctrl #(
   parameter int AW = 21,
   parameter int MAXPOLL = 65535
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic [3:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   output logic [AW-1:0] o_flash_addr,
   output logic o_flash_ce_n,
   output logic o_flash_oe_n,
   input wire logic [15:0] i_flash_dq,
   input wire logic i_ready_busy_out,
   output logic o_ready_busy_out_oe
);
   // ----------------------------------------
   // state and registers
   // ----------------------------------------
   fsf_pkg::fsf_st_e st;
   logic [AW-1:0] poll_addr;
   logic [7:0] exp_byte;
   logic mode_toggle;
   logic [7:0] cnt;
   logic [15:0] polls;
   logic [15:0] last_dq;
   logic have_last;
   logic busy;
   fsf_pkg::fsf_res_s res;
   logic timed_out;
   logic [15:0] dq_s;
   logic rb_s;
   logic [15:0] sample;
   fsf_sync #(.W(16)) u_sync_dq (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_d(i_flash_dq), .o_q(dq_s));
   fsf_sync #(.W(1)) u_sync_rb (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_d(i_ready_busy_out), .o_q(rb_s));
   // ----------------------------------------
   // decode of status sample
   // ----------------------------------------
   wire start = i_reg_wr && (i_reg_addr == fsf_pkg::A_CTRL) && i_reg_wdata[0] && !busy;
   wire tog1_same = sample[fsf_pkg::B_TOG1] == last_dq[fsf_pkg::B_TOG1];
   wire tog2_diff = sample[fsf_pkg::B_TOG2] != last_dq[fsf_pkg::B_TOG2];
   wire poll_match = sample[fsf_pkg::B_POLL] == exp_byte[fsf_pkg::B_POLL];
   wire tmo_seen = sample[fsf_pkg::B_TMO];
   wire data_done = poll_match;
   wire tog_done = have_last && tog1_same;
   wire step_done = mode_toggle ? tog_done : data_done;
   wire cnt_end = cnt == 8'h00;
   wire poll_limit = polls == MAXPOLL[15:0];
   // ----------------------------------------
   // poll sequencer: one distinct read per sample
   // ----------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         st <= fsf_pkg::ST_IDLE;
         busy <= 1'b0;
         cnt <= 8'h00;
         polls <= 16'h0000;
         have_last <= 1'b0;
         last_dq <= fsf_pkg::DQ_RST;
         sample <= fsf_pkg::DQ_RST;
         res <= '0;
         timed_out <= 1'b0;
         o_flash_ce_n <= 1'b1;
         o_flash_oe_n <= 1'b1;
      end else begin
         case (st)
            fsf_pkg::ST_IDLE: begin
               if (start) begin
                  busy <= 1'b1;
                  polls <= 16'h0000;
                  have_last <= 1'b0;
                  res <= '0;
                  timed_out <= 1'b0;
                  st <= fsf_pkg::ST_RD;
                  cnt <= 8'(fsf_pkg::RD_CYC + 2);
                  o_flash_ce_n <= 1'b0;
                  o_flash_oe_n <= 1'b0;
               end
            end
            fsf_pkg::ST_RD: begin
               if (cnt_end) begin
                  sample <= dq_s;
                  o_flash_ce_n <= 1'b1;
                  o_flash_oe_n <= 1'b1;
                  st <= fsf_pkg::ST_EVAL;
               end else begin
                  cnt <= cnt - 8'h01;
               end
            end
            fsf_pkg::ST_EVAL: begin
               polls <= polls + 16'h0001;
               last_dq <= sample;
               have_last <= 1'b1;
               res.erwin_closed <= sample[fsf_pkg::B_ERWIN];
               res.ready <= rb_s;
               if (step_done) begin
                  res.done <= 1'b1;
                  busy <= 1'b0;
                  st <= fsf_pkg::ST_IDLE;
               end else if (tmo_seen && (!mode_toggle || (have_last && tog2_diff))) begin
                  res.fail <= 1'b1;
                  res.done <= 1'b1;
                  busy <= 1'b0;
                  st <= fsf_pkg::ST_IDLE;
               end else if (poll_limit) begin
                  timed_out <= 1'b1;
                  busy <= 1'b0;
                  st <= fsf_pkg::ST_IDLE;
               end else begin
                  cnt <= 8'(fsf_pkg::GAP_CYC);
                  st <= fsf_pkg::ST_GAP;
               end
            end
            fsf_pkg::ST_GAP: begin
               if (cnt_end) begin
                  cnt <= 8'(fsf_pkg::RD_CYC + 2);
                  o_flash_ce_n <= 1'b0;
                  o_flash_oe_n <= 1'b0;
                  st <= fsf_pkg::ST_RD;
               end else begin
                  cnt <= cnt - 8'h01;
               end
            end
            default: st <= fsf_pkg::ST_IDLE;
         endcase
      end
   end
   // ----------------------------------------
   // software registers; reads answer one cycle later
   // ----------------------------------------
   wire [31:0] stat_word = {24'h0, rb_s, timed_out, 1'b0, busy, res.erwin_closed, res.ready, res.fail, res.done};
   wire [31:0] rd_mux = (i_reg_addr == fsf_pkg::A_CTRL) ? {31'h0, mode_toggle} :
                        (i_reg_addr == fsf_pkg::A_ADDR) ? 32'(poll_addr) :
                        (i_reg_addr == fsf_pkg::A_EXP) ? {24'h0, exp_byte} :
                        (i_reg_addr == fsf_pkg::A_STAT) ? stat_word :
                        (i_reg_addr == fsf_pkg::A_DATA) ? {16'h0, last_dq} : 32'h0;
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         o_reg_rdata <= 32'h0;
         poll_addr <= '0;
         exp_byte <= 8'h00;
         mode_toggle <= 1'b0;
         o_flash_addr <= '0;
         o_ready_busy_out_oe <= 1'b0;
      end else begin
         o_reg_rdata <= i_reg_rd ? rd_mux : 32'h0;
         o_ready_busy_out_oe <= 1'b0;
         o_flash_addr <= poll_addr;
         if (i_reg_wr && !busy) begin
            if (i_reg_addr == fsf_pkg::A_CTRL) mode_toggle <= i_reg_wdata[1];
            if (i_reg_addr == fsf_pkg::A_ADDR) poll_addr <= i_reg_wdata[AW-1:0];
            if (i_reg_addr == fsf_pkg::A_EXP) exp_byte <= i_reg_wdata[7:0];
         end
      end
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_read_strobe_gap: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      $rose(o_flash_oe_n) |=> o_flash_oe_n) else $error("oe not released between reads");
   a_poll_match_done: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (st == fsf_pkg::ST_EVAL && !mode_toggle && poll_match) |=> (res.done && !busy))
      else $error("data poll match not finished");
   a_toggle_stop_done: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (st == fsf_pkg::ST_EVAL && mode_toggle && have_last && tog1_same) |=> res.done)
      else $error("toggle stop not finished");
   a_timeout_fail: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (st == fsf_pkg::ST_EVAL && !mode_toggle && !poll_match && tmo_seen) |=> res.fail)
      else $error("timeout flag not reported");
   a_addr_in_bank: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (!o_flash_oe_n) |-> (o_flash_addr == poll_addr)) else $error("poll address drifted");
   // ----------------------------------------
   // helper: length of the current read strobe
   // ----------------------------------------
   // counting here keeps the checks free of long repetitions
   logic [7:0] oe_low_cnt;
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         oe_low_cnt <= 8'h00;
      end else if (!o_flash_oe_n) begin
         oe_low_cnt <= oe_low_cnt + 8'h01;
      end else begin
         oe_low_cnt <= 8'h00;
      end
   end
   // ----------------------------------------
   // checks on strobes, limits and reported flags
   // ----------------------------------------
   a_strobe_pair: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      o_flash_ce_n == o_flash_oe_n)
      else $error("chip and output strobes split");
   a_read_length: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      $rose(o_flash_oe_n) |-> (oe_low_cnt == 8'(fsf_pkg::RD_CYC + 3)))
      else $error("read strobe length wrong");
   a_oe_only_busy: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      !o_flash_oe_n |-> busy)
      else $error("flash read outside a poll");
   a_rb_never_driven: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      !o_ready_busy_out_oe)
      else $error("ready line driven by host");
   a_limit_stops: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (st == fsf_pkg::ST_EVAL && poll_limit && !step_done && !tmo_seen) |=> (timed_out && !busy))
      else $error("poll limit not honoured");
   a_toggle_fail: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (st == fsf_pkg::ST_EVAL && mode_toggle && !tog_done && tmo_seen && have_last && tog2_diff) |=> res.fail)
      else $error("failing block not reported");
   a_ready_copy: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (st == fsf_pkg::ST_EVAL) |=> (res.ready == $past(rb_s)))
      else $error("ready flag not captured");
   a_erwin_copy: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (st == fsf_pkg::ST_EVAL) |=> (res.erwin_closed == $past(sample[fsf_pkg::B_ERWIN])))
      else $error("erase window flag not captured");
   a_rdata_idle: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      !$past(i_reg_rd) |-> (o_reg_rdata == 32'h0))
      else $error("read data outside its cycle");
   a_start_busy: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      start |=> busy)
      else $error("start did not begin a poll");
endmodule
`default_nettype wire

//--- bench/fsf_flash_model.sv
// behavioural flash device answering status reads on its data lines
`default_nettype none
module fsf_flash_model (
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_go,
   input wire logic [1:0] i_kind,
   input wire logic [7:0] i_len,
   input wire logic [15:0] i_word,
   output logic [15:0] o_dq,
   output logic o_pull_low
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] kind = 2'h0;
   logic [7:0] left = 8'h00;
   logic tog = 1'b0;
   logic [15:0] last = 16'h0000;
   logic [15:0] st;
   // ----------------------------------------
   // status word: kind 1 program, 2 erase, 3 program past limits
   // ----------------------------------------
   always_comb begin
      st = i_word;
      if (kind != 2'h0) begin
         st[7] = (kind == 2'h2) ? 1'b0 : ~i_word[7];
         st[6] = tog;
         st[5] = (kind == 2'h3);
         st[3] = (kind == 2'h2);
         st[2] = (kind == 2'h2) ? tog : 1'b1;
      end
   end
   // every finished read flips the toggle state and counts the routine down
   always @(posedge i_oe_n or posedge i_go) begin
      if (i_go) begin
         kind <= i_kind;
         left <= i_len;
      end else begin
         tog <= ~tog;
         last <= st;
         if (left != 8'h00) left <= left - 8'h01;
         if (left == 8'h01 && kind != 2'h3) kind <= 2'h0;
      end
   end
   // a released bus must not keep showing the last word
   assign o_dq = (i_oe_n || i_ce_n) ? ~last : st;
   assign o_pull_low = (kind != 2'h0);
endmodule
`default_nettype wire

//--- bench/flash_operation_status_flags_tb_top.sv
// testbench for the flash status poll controller
`default_nettype none
module flash_operation_status_flags_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
   logic [3:0] ra = 4'h0;
   logic [31:0] wd = 32'h0, s;
   logic [1:0] kind = 2'h0;
   logic [7:0] len = 8'h00;
   logic [15:0] word = 16'h0000;
   wire logic [31:0] rdat;
   wire logic [20:0] fa;
   wire logic [15:0] dq;
   wire logic ce_n, oe_n, pull_low, rb_oe, rb;
   int err_total = 0, checks = 0, cyc = 0;
   // open-drain line with board pull-up
   assign rb = !(pull_low || rb_oe);
   fsf_poll_ctrl #(.MAXPOLL(8)) fsf_poll_ctrl_inst (.i_core_clk(clk), .i_nrst(nrst), .i_reg_addr(ra),
      .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .o_flash_addr(fa),
      .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n), .i_flash_dq(dq), .i_ready_busy_out(rb),
      .o_ready_busy_out_oe(rb_oe));
   fsf_flash_model fsf_flash_model_inst (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_go(go), .i_kind(kind),
      .i_len(len), .i_word(word), .o_dq(dq), .o_pull_low(pull_low));
   initial begin
      forever #25 clk = ~clk;
   end
   // ----------------------------------------
   // access tasks and checks
   // ----------------------------------------
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      ra <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rreg(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      ra <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdat;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // start a device routine, start a poll, wait for done, fail or limit
   task automatic run(input logic [1:0] k, input logic [7:0] n, input logic [15:0] w, input logic [31:0] c);
      kind <= k;
      len <= n;
      word <= w;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      wreg(fsf_pkg::A_ADDR, 32'h0000_1000);
      wreg(fsf_pkg::A_EXP, {24'h0, w[7:0]});
      wreg(fsf_pkg::A_CTRL, c);
      rreg(fsf_pkg::A_STAT, s);
      check("stat busy and line low", s & 32'h90, 32'h10);
      repeat (200) if ((s & 32'h43) == 32'h0) rreg(fsf_pkg::A_STAT, s);
   endtask
   // cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         give_verdict();
      end
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      // the ready pin passes two flops after reset before it reads high
      repeat (2) @(posedge clk);
      rreg(fsf_pkg::A_STAT, s);
      check("flash strobes idle", {30'h0, ce_n, oe_n}, 32'h3);
      check("stat idle", s & 32'h90, 32'h80);
      check("ready line enable", {31'h0, rb_oe}, 32'h0);
      rreg(4'hf, s);
      check("unmapped read", s, 32'h0);
      run(2'h1, 8'h03, 16'h00a5, 32'h1);
      check("program poll", s & 32'h43, 32'h01);
      rreg(fsf_pkg::A_DATA, s);
      check("program data", s & 32'hffff, 32'h00a5);
      check("poll address", {11'h0, fa}, 32'h0000_1000);
      run(2'h2, 8'h03, 16'h00ff, 32'h3);
      check("erase toggle poll", s & 32'h43, 32'h01);
      run(2'h3, 8'hc8, 16'h00a5, 32'h1);
      check("timeout fail", s & 32'h02, 32'h02);
      run(2'h2, 8'hc8, 16'h00ff, 32'h3);
      check("endless erase", s & 32'h41, 32'h40);
      rreg(fsf_pkg::A_DATA, s);
      check("erase sample", s & 32'h88, 32'h08);
      give_verdict();
   end
endmodule
`default_nettype wire
